/* bench/chip_protection_control_test.sv */
// self-checking bench for the chip protection control byte
// assumes cpc_cfg.svh on the include path; grant requests held high
`include "cpc_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module chip_protection_control_test;
  import cpc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk_i = 1'b0, arst_n_i = 1'b0, wake_rst_n_i = 1'b1;
  logic       boot_load_i = 1'b0, req = 1'b0;
  cpc_byte_t  boot_val_i = 8'h00, sfr_wdata, sfr_rdata, otp_q;
  logic [7:0] sfr_addr;
  logic       sfr_wr, sfr_rd, sfr_sel, rd_ok, wr_ok, otp_en, dbg_ok;
  cpc_level_t lvl;
  int         err_total = 0, samples_checked = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  cpc_cpu_model cpc_cpu_model_inst (.sys_clk_i(sys_clk_i),
    .sfr_rdata_i(sfr_rdata), .sfr_sel_i(sfr_sel), .sfr_addr_o(sfr_addr),
    .sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd), .sfr_wdata_o(sfr_wdata));
  cpc_chip_protection_control cpc_chip_protection_control_inst (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .wake_rst_n_i(wake_rst_n_i), .boot_load_i(boot_load_i),
    .boot_val_i(boot_val_i), .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr),
    .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata),
    .sfr_sel_o(sfr_sel), .nvm_rd_req_i(req), .nvm_wr_req_i(req),
    .nvm_rd_ok_o(rd_ok), .nvm_wr_ok_o(wr_ok), .otp_rd_req_i(req),
    .otp_rdata_i(8'ha5), .otp_en_o(otp_en), .otp_rdata_o(otp_q),
    .dbg_req_i(req), .dbg_ok_o(dbg_ok), .program_level_o(lvl));
  task automatic end_of_test();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic tick(); @(posedge sys_clk_i); #1; endtask : tick
  task automatic chk_reg(input cpc_byte_t e);
    cpc_byte_t d;
    logic      s;
    cpc_cpu_model_inst.rd(`CPC_SFR_ADDR, d, s);
    `CHK({s, d}, {1'b1, e})
  endtask : chk_reg
  // boot strobe is one cycle wide
  task automatic boot(input cpc_byte_t v);
    @(posedge sys_clk_i);
    boot_val_i  <= v;
    boot_load_i <= 1'b1;
    @(posedge sys_clk_i);
    boot_load_i <= 1'b0;
  endtask : boot
  // watchdog: the tests need well under 200 cycles
  initial begin
    #20us;
    err_total++;
    end_of_test();
  end
  // main sequence
  initial begin
    cpc_byte_t d;
    logic      s;
    repeat (4) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    req      <= 1'b1;
    tick();
    chk_reg(8'h20);
    `CHK(lvl, 3'h0)
    boot(`CPC_LVL_FACTORY);
    chk_reg(8'h21);
    cpc_cpu_model_inst.wr(8'hda, 8'h20);
    cpc_cpu_model_inst.wr(8'hda, 8'h00);
    chk_reg(8'h21);
    cpc_cpu_model_inst.wr(8'hdb, 8'hff);
    cpc_cpu_model_inst.rd(8'hdb, d, s);
    `CHK({s, d}, 9'h000)
    cpc_cpu_model_inst.wr(8'hda, 8'h0a);
    chk_reg(8'h2b);
    `CHK(lvl, `CPC_LVL_USER)
    `CHK(wr_ok, 1'b1)
    $display("test write and level done");
    cpc_cpu_model_inst.wr(8'hda, 8'h04);
    tick();
    `CHK({rd_ok, wr_ok}, 2'b10)
    `CHK({otp_en, otp_q}, 9'h1a5)
    `CHK(dbg_ok, 1'b1)
    cpc_cpu_model_inst.wr(8'hda, 8'h50);
    tick();
    `CHK({otp_en, otp_q}, 9'h000)
    `CHK(dbg_ok, 1'b0)
    @(posedge sys_clk_i) wake_rst_n_i <= 1'b0;
    @(posedge sys_clk_i) wake_rst_n_i <= 1'b1;
    chk_reg(8'h3f);
    `CHK(dbg_ok, 1'b1)
    cpc_cpu_model_inst.wr(8'hda, 8'h80);
    tick();
    `CHK({rd_ok, wr_ok}, 2'b00)
    $display("test locks done");
    @(posedge sys_clk_i) arst_n_i <= 1'b0;
    @(posedge sys_clk_i) arst_n_i <= 1'b1;
    chk_reg(8'h20);
    boot(8'h11);
    chk_reg(8'h31);
    $display("test power cycle done");
    end_of_test();
  end
endmodule : chip_protection_control_test

/* bench/cpc_cpu_model.sv */
// processor side model driving the sfr strobes of the protection byte
// assumes caller starts after reset release; strobes launch on rising edge
module cpc_cpu_model
  import cpc_pkg::*;
(
  input  wire logic      sys_clk_i,   // processor clock
  input  wire cpc_byte_t sfr_rdata_i, // read data
  input  wire logic      sfr_sel_i,   // read hit flag
  output logic [7:0]     sfr_addr_o,  // direct sfr address
  output logic           sfr_wr_o,    // write strobe
  output logic           sfr_rd_o,    // read strobe
  output cpc_byte_t      sfr_wdata_o  // write data
);
  // bus idle at time zero
  initial begin
    sfr_addr_o  = 8'h00;
    sfr_wr_o    = 1'b0;
    sfr_rd_o    = 1'b0;
    sfr_wdata_o = 8'h00;
  end
  // whole byte by direct address, no bit access
  task automatic wr(input logic [7:0] a, input cpc_byte_t d);
    @(posedge sys_clk_i);
    sfr_addr_o  <= a;
    sfr_wdata_o <= d;
    sfr_wr_o    <= 1'b1;
    @(posedge sys_clk_i);
    sfr_wr_o    <= 1'b0;
    sfr_wdata_o <= ~d; // stale data must not look valid
  endtask : wr
  // data stands one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output cpc_byte_t d,
                    output logic s);
    @(posedge sys_clk_i);
    sfr_addr_o <= a;
    sfr_rd_o   <= 1'b1;
    @(posedge sys_clk_i);
    sfr_rd_o   <= 1'b0;
    #1;
    d = sfr_rdata_i;
    s = sfr_sel_i;
  endtask : rd
endmodule : cpc_cpu_model

/* src/cpc_cfg.svh */
// constants for the chip protection control block
// assumes inclusion by bare name from the bench and the two src modules
`ifndef CPC_CFG_SVH
`define CPC_CFG_SVH
`define CPC_SFR_ADDR      8'hda
`define CPC_BIT_NVM_LOCK  7
`define CPC_BIT_DBG_OFF   6
`define CPC_BIT_RSVD      5
`define CPC_BIT_OTP_LOCK  4
`define CPC_BIT_NVM_WR    3
`define CPC_LVL_MSB       2
`define CPC_RESET_VAL     8'h20
`define CPC_WR_MASK       8'hdf
`define CPC_OTP_BLANK     8'h00
`define CPC_LVL_FACTORY   3'h1
`define CPC_LVL_USER      3'h3
`define CPC_LVL_RUN       3'h7
`endif

/* src/cpc_chip_protection_control.sv */
// chip protection control byte register and its lock gating
// assumes boot loader, nvm, otp and debug port logic live outside
//
// How it works
// - boot loader strobes the stored nvm value into the register at 0xda
// - software write of one sets a bit, zero leaves it unchanged
// - only power-on reset clears bits (shutdown wake clears bit 6 alone), boot reloads them
// - writes touch the live byte only, no path back to nvm
// - bit 7 set blocks every nvm read and write
// - debug disable bit 6 clears only on power-on reset or shutdown wake
// - debug disable set makes the two-wire debug port refuse all access
// - otp lock bit 4 disables the store and forces reads to 0x00
// - nvm write lock bit 3 counts only at run level 3'b11x
// - bits 2:0 are the set-only program level 001/011/111
//
// timing seen from the processor side:
//   write: strobe, address and data sampled on one rising edge; the
//   live byte holds the new bits from that same edge on
//   read: strobe and address sampled on one rising edge; data and the
//   select flag stand for exactly one cycle after that edge
//   grants: every grant output is the request of the previous cycle
//   gated by the locks of the previous cycle, so a lock written in
//   cycle n first blocks a request sampled in cycle n+1
//
// limitations:
//   unoccupied addresses are not decoded; a read there returns zero
//   with the select flag low, a write there is dropped
//   the reserved bit is stored as one by reset and never written, the
//   read view pins it to one regardless
//   the debug disable bit has its own flop because a second reset
//   (shutdown wake) clears it; the copy inside the sticky byte is unused
`include "cpc_cfg.svh"
module cpc_chip_protection_control
  import cpc_pkg::*;
(
  input  wire logic       sys_clk_i,       // processor clock, 100 MHz
  input  wire logic       arst_n_i,        // main power-on reset, low
  input  wire logic       wake_rst_n_i,    // wake-from-shutdown reset, low
  input  wire logic       boot_load_i,     // boot loader load strobe
  input  wire cpc_byte_t  boot_val_i,      // protection byte from nvm
  input  wire logic [7:0] sfr_addr_i,      // direct sfr address
  input  wire logic       sfr_wr_i,        // sfr write strobe
  input  wire logic       sfr_rd_i,        // sfr read strobe
  input  wire cpc_byte_t  sfr_wdata_i,     // sfr write data
  output cpc_byte_t       sfr_rdata_o,     // sfr read data
  output logic            sfr_sel_o,       // read data valid for this byte
  input  wire logic       nvm_rd_req_i,    // nvm read request
  input  wire logic       nvm_wr_req_i,    // nvm write request
  output logic            nvm_rd_ok_o,     // nvm read allowed
  output logic            nvm_wr_ok_o,     // nvm write allowed
  input  wire logic       otp_rd_req_i,    // otp read request
  input  wire cpc_byte_t  otp_rdata_i,     // raw otp data
  output logic            otp_en_o,        // otp store enable
  output cpc_byte_t       otp_rdata_o,     // gated otp data
  input  wire logic       dbg_req_i,       // debug port access request
  output logic            dbg_ok_o,        // debug access accepted
  output cpc_level_t      program_level_o  // chip program level
);
  cpc_byte_t  live;
  logic       dbg_off_reg;
  logic       dbg_off_next;
  logic       reg_hit;
  logic       sw_wr;
  logic       run_level;
  logic       nvm_lock;
  logic       nvm_wr_lock;
  logic       otp_lock;
  cpc_byte_t  rd_view;
  cpc_byte_t  rdata_reg;
  logic       sel_reg;
  logic       nvm_rd_ok_reg;
  logic       nvm_wr_ok_reg;
  logic       otp_en_reg;
  cpc_byte_t  otp_rdata_reg;
  logic       dbg_ok_reg;
  logic       dbg_rst_n;

  // address decode; only the exact byte address is ours
  assign reg_hit = (sfr_addr_i == `CPC_SFR_ADDR);
  assign sw_wr   = sfr_wr_i & reg_hit;

  // boot load and software write both or into the same sticky byte;
  // nothing here writes back to nvm
  cpc_sticky_byte u_sticky (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .set_i     (boot_load_i | sw_wr),
    .set_val_i (boot_load_i ? (boot_val_i | (sw_wr ? sfr_wdata_i : 8'h00))
                            : sfr_wdata_i),
    .val_o     (live)
  );

  // debug disable also cleared by shutdown wake, kept apart for that
  assign dbg_off_next = dbg_off_reg
    | (sw_wr & sfr_wdata_i[`CPC_BIT_DBG_OFF])
    | (boot_load_i & boot_val_i[`CPC_BIT_DBG_OFF]);

  // both resets merged into one async clear; the flop then has a single
  // reset pin, which keeps the two reset trees from racing each other
  assign dbg_rst_n = arst_n_i & wake_rst_n_i;

  always_ff @(posedge sys_clk_i or negedge dbg_rst_n) begin
    if (!dbg_rst_n) begin
      dbg_off_reg <= 1'b0;
    end else begin
      dbg_off_reg <= dbg_off_next;
    end
  end

  // lock decode
  assign run_level   = (live[`CPC_LVL_MSB:1] == 2'h3);
  assign nvm_lock    = live[`CPC_BIT_NVM_LOCK];
  assign nvm_wr_lock = live[`CPC_BIT_NVM_WR] & run_level;
  assign otp_lock    = live[`CPC_BIT_OTP_LOCK];

  // read view: reserved bit pinned to one, debug bit from its own flop
  assign rd_view = {live[`CPC_BIT_NVM_LOCK], dbg_off_reg, 1'b1,
                    live[4:0]};

  // registered outputs; grants lag requests by one cycle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg     <= 8'h00;
      sel_reg       <= 1'b0;
      nvm_rd_ok_reg <= 1'b0;
      nvm_wr_ok_reg <= 1'b0;
      otp_en_reg    <= 1'b0;
      otp_rdata_reg <= `CPC_OTP_BLANK;
      dbg_ok_reg    <= 1'b0;
    end else begin
      rdata_reg     <= (sfr_rd_i & reg_hit) ? rd_view : 8'h00;
      sel_reg       <= sfr_rd_i & reg_hit;
      nvm_rd_ok_reg <= nvm_rd_req_i & ~nvm_lock;
      nvm_wr_ok_reg <= nvm_wr_req_i & ~nvm_lock & ~nvm_wr_lock;
      otp_en_reg    <= ~otp_lock;
      otp_rdata_reg <= (otp_rd_req_i & ~otp_lock) ? otp_rdata_i
                                                  : `CPC_OTP_BLANK;
      dbg_ok_reg    <= dbg_req_i & ~dbg_off_reg;
    end
  end

  assign sfr_rdata_o     = rdata_reg;
  assign sfr_sel_o       = sel_reg;
  assign nvm_rd_ok_o     = nvm_rd_ok_reg;
  assign nvm_wr_ok_o     = nvm_wr_ok_reg;
  assign otp_en_o        = otp_en_reg;
  assign otp_rdata_o     = otp_rdata_reg;
  assign dbg_ok_o        = dbg_ok_reg;
  assign program_level_o = live[`CPC_LVL_MSB:0];

  // checks
  a_nvm_lock_block: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    nvm_lock |=> !nvm_rd_ok_o && !nvm_wr_ok_o)
    else $error("nvm access granted while locked");
  a_dbg_refuse: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    dbg_off_reg |=> !dbg_ok_o)
    else $error("debug access granted while disabled");
  a_dbg_sticky: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i || !wake_rst_n_i)
    dbg_off_reg |=> dbg_off_reg)
    else $error("debug disable cleared by software");
  a_otp_zero: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    otp_lock |=> otp_rdata_o == 8'h00 && !otp_en_o)
    else $error("otp data visible while locked");
  a_wr_lock_level: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (nvm_wr_req_i && !nvm_lock && !run_level) |=> nvm_wr_ok_o)
    else $error("write lock applied outside run level");
  a_wr_lock_run: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (live[3] && run_level) |=> !nvm_wr_ok_o)
    else $error("nvm write granted at run level while locked");
  a_sw_set_bit: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (sw_wr && sfr_wdata_i[7]) |=> live[7])
    else $error("write of one did not set bit");
  a_boot_load: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    boot_load_i |=>
      (live & $past(boot_val_i) & 8'hdf) == ($past(boot_val_i) & 8'hdf))
    else $error("boot value not loaded");
  a_rsvd_one: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (sfr_rd_i && reg_hit) |=> sfr_rdata_o[5] && sfr_sel_o)
    else $error("reserved bit not read as one");
  a_level_sticky: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ($past(live[2:0]) & ~live[2:0]) == 3'h0)
    else $error("program level bit cleared");
  // a write of zeros must leave every bit alone; ones only add bits
  a_wr_or_only: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (sw_wr && !boot_load_i) |=>
      live == ($past(live) | ($past(sfr_wdata_i) & 8'hdf)))
    else $error("write did not or into the live byte");
  // open locks must not swallow requests
  a_nvm_rd_open: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (nvm_rd_req_i && !nvm_lock) |=> nvm_rd_ok_o)
    else $error("nvm read refused while unlocked");
  a_dbg_open: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (dbg_req_i && !dbg_off_reg) |=> dbg_ok_o)
    else $error("debug access refused while enabled");
  a_otp_pass: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (otp_rd_req_i && !otp_lock) |=>
      (otp_en_o && otp_rdata_o == $past(otp_rdata_i)))
    else $error("otp data not passed while unlocked");
  // other addresses are not ours: no select, no data
  a_rd_miss: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (sfr_rd_i && !reg_hit) |=> (!sfr_sel_o && sfr_rdata_o == 8'h00))
    else $error("read answered at a foreign address");

  c_boot_run: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    boot_load_i && boot_val_i[2:0] == `CPC_LVL_RUN);
  c_dbg_off: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    dbg_req_i && dbg_off_reg);
  c_otp_lock: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    otp_rd_req_i && otp_lock);
  c_rd_reg: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    sfr_rd_i && reg_hit);
  c_wake_clear: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    dbg_off_reg ##1 !dbg_off_reg);
endmodule : cpc_chip_protection_control

/* src/cpc_pkg.sv */
// types shared by the chip protection control block
// assumes cpc_cfg.svh is on the include path
package cpc_pkg;
  typedef logic [7:0] cpc_byte_t;
  typedef logic [2:0] cpc_level_t;
endpackage : cpc_pkg

/* src/cpc_sticky_byte.sv */
// sticky set-only byte: bits set by load or write, cleared only by reset
// assumes both strobes are single-cycle and synchronous to sys_clk_i
`include "cpc_cfg.svh"
module cpc_sticky_byte
  import cpc_pkg::*;
(
  input  wire logic      sys_clk_i,  // processor clock
  input  wire logic      arst_n_i,   // power-on reset, active low
  input  wire logic      set_i,      // or-in strobe
  input  wire cpc_byte_t set_val_i,  // bits to set
  output cpc_byte_t      val_o       // stored byte
);
  cpc_byte_t val_reg;
  cpc_byte_t val_next;

  // or-in only; zeros never clear anything
  assign val_next = set_i ? (val_reg | (set_val_i & `CPC_WR_MASK)) : val_reg;

  // only power-on reset returns bits to their reset value
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      val_reg <= `CPC_RESET_VAL;
    end else begin
      val_reg <= val_next;
    end
  end

  assign val_o = val_reg;

  a_never_clears: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ($past(val_reg) & ~val_reg) == 8'h00)
    else $error("sticky bit cleared");
endmodule : cpc_sticky_byte
